// ---- core/tss_pkg.sv ----
/*
  constants and types of the sequencer.
  assumes one clock at CLK_MHZ.
*/
package tss_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 250;
  localparam int STEP_NS   = 2000;                            // dwell of one self-test step
  localparam int STEP_CYC  = (STEP_NS * CLK_MHZ + 999) / 1000; // least time, rounded up
  localparam int QUIET_CYC = 4;                               // idle cycles before wait ends

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LVL_W  = 16;
  localparam int NMOD   = 4;
  localparam int QW     = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIG_VOLT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TRIG_CURR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OUT_VOLT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUT_CURR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RESULT    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CB_CONT  = 0;
  localparam int CB_INIT  = 1;
  localparam int CB_TRG   = 2;
  localparam int CB_GET   = 3;
  localparam int CB_RST   = 4;
  localparam int CB_TEST  = 5;
  localparam int CB_WAI   = 6;
  localparam int SB_WTG   = 0;
  localparam int SB_BUSY  = 1;
  localparam int SB_WAI   = 2;
  localparam int SB_LSTN  = 3;
  localparam int IRQ_W    = 3;
  localparam int IB_TRIG  = 0;
  localparam int IB_TEST  = 1;
  localparam int IB_WAI   = 2;
  localparam logic [LVL_W-1:0] LVL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // self-test output level
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_ZERO = 2'b00,
    LVL_POS  = 2'b01,
    LVL_NEG  = 2'b10
  } lvl_t;
endpackage

// ---- core/tss_ctl_if.sv ----
/*
  control carrier between the sequencer top and its units.
  assumes one shared clock.
*/
interface tss_ctl_if #(
  parameter int NMOD = tss_pkg::NMOD
);
  import tss_pkg::*;
  // trigger group
  logic            init;
  logic            trg;
  logic            get;
  logic            listen;
  logic            cont_wr;
  logic            cont_val;
  logic            rst_cmd;
  logic            wtg;
  logic            cont;
  logic            fire;
  // self-test group
  logic            test_start;
  logic            test_busy;
  logic            test_done;
  lvl_t            test_level;
  logic            measure;
  logic [NMOD-1:0] present;
  logic [NMOD-1:0] has_relay;
  logic [NMOD-1:0] ques_nz;
  logic [NMOD-1:0] fail;
  logic [NMOD-1:0] relay_close;
  logic [NMOD-1:0] relay_neg;

  modport ctrl (
    output init, trg, get, listen, cont_wr, cont_val, rst_cmd,
    output test_start, present, has_relay, ques_nz,
    input  wtg, cont, fire, test_busy, test_done, test_level, measure,
    input  fail, relay_close, relay_neg
  );
  modport trig (
    input  init, trg, get, listen, cont_wr, cont_val, rst_cmd,
    output wtg, cont, fire
  );
  modport test (
    input  test_start, present, has_relay, ques_nz,
    output test_busy, test_done, test_level, measure, fail, relay_close, relay_neg
  );
endinterface

// ---- core/tss_trigger.sv ----
/*
  trigger arming: single and continuous arming, waiting flag, event.
  assumes one-cycle command strobes on the same clock.
*/
module tss_trigger (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // control carrier
  tss_ctl_if.trig   cif
);
  import tss_pkg::*;

  typedef struct packed {
    logic cont;
    logic wtg;
    logic fire;
  } trig_state_t;

  trig_state_t q;
  trig_state_t d;
  logic        hit;

  // next state of the arming logic
  always_comb begin
    d      = q;
    d.fire = 1'b0;
    hit    = (cif.trg | cif.get) & cif.listen & q.wtg;
    // (RULE14) continuous arming set
    if (cif.cont_wr) begin
      d.cont = cif.cont_val;
    end
    if (cif.rst_cmd) begin
      // (RULE14) reset forces off
      d.cont = 1'b0;
      d.wtg  = 1'b0;
    end else if (hit) begin
      // (RULE1) fire only armed
      // (RULE4) listener gate applied
      d.fire = 1'b1;
      // (RULE3) rearm when continuous
      // (RULE6) otherwise disarm after one
      d.wtg  = q.cont | (cif.cont_wr & cif.cont_val);
    end else if ((cif.init & ~q.cont) | (cif.cont_wr & cif.cont_val)) begin
      // (RULE5) single arm by init
      // (RULE15) arming sets waiting flag
      d.wtg = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign cif.cont = q.cont;
  assign cif.wtg  = q.wtg;
  assign cif.fire = q.fire;
endmodule

// ---- core/tss_selftest.sv ----
/*
  self-test sequencer: steps modules through test levels and relays,
  then judges each connected module by its questionable status.
  assumes questionable flags are valid at the judge step.
*/
module tss_selftest #(
  parameter int NMOD     = tss_pkg::NMOD,
  parameter int STEP_CYC = tss_pkg::STEP_CYC
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // control carrier
  tss_ctl_if.test   cif
);
  import tss_pkg::*;

  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(STEP_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPEN  = 3'b001,
    ST_POS   = 3'b010,
    ST_ZERO1 = 3'b011,
    ST_SWAP  = 3'b100,
    ST_NEG   = 3'b101,
    ST_ZERO2 = 3'b110,
    ST_JUDGE = 3'b111
  } st_t;

  typedef struct packed {
    st_t             st;
    logic [CW-1:0]   cnt;
    lvl_t            level;
    logic [NMOD-1:0] close;
    logic [NMOD-1:0] neg;
    logic            busy;
    logic            measure;
    logic            done;
    logic [NMOD-1:0] fail;
  } test_state_t;

  test_state_t q;
  test_state_t d;
  logic        step_end;

  // sequence through the test steps
  always_comb begin
    d         = q;
    d.measure = 1'b0;
    d.done    = 1'b0;
    step_end  = (q.cnt == CNT_END);
    d.cnt     = step_end ? '0 : CW'(q.cnt + 1'b1);
    case (q.st)
      ST_IDLE: begin
        d.cnt = '0;
        if (cif.test_start) begin
          // (RULE7) open relays first
          d.st    = ST_OPEN;
          d.close = '0;
          d.neg   = '0;
          d.level = LVL_ZERO;
        end
      end
      ST_OPEN: begin
        if (step_end) begin
          d.st    = ST_POS;
          // (RULE8) relayless modules get levels only
          d.close = cif.has_relay;
          d.level = LVL_POS;
        end
      end
      ST_POS: begin
        if (step_end) begin
          // (RULE7) measure max positive
          d.measure = 1'b1;
          d.st      = ST_ZERO1;
          d.level   = LVL_ZERO;
        end
      end
      ST_ZERO1: begin
        if (step_end) begin
          d.measure = 1'b1;
          d.st      = ST_SWAP;
          d.neg     = cif.has_relay;
        end
      end
      ST_SWAP: begin
        if (step_end) begin
          d.st    = ST_NEG;
          d.level = LVL_NEG;
        end
      end
      ST_NEG: begin
        if (step_end) begin
          // (RULE7) measure max negative
          d.measure = 1'b1;
          d.st      = ST_ZERO2;
          d.level   = LVL_ZERO;
          d.neg     = '0;
        end
      end
      ST_ZERO2: begin
        if (step_end) begin
          d.st = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        // (RULE9) pass only if zero
        // (RULE10) every connected module judged
        d.fail = cif.present & cif.ques_nz;
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    d.busy = (d.st != ST_IDLE);
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign cif.test_busy  = q.busy;
  assign cif.test_done  = q.done;
  assign cif.test_level = q.level;
  assign cif.measure    = q.measure;
  assign cif.fail       = q.fail;
  assign cif.relay_close = q.close;
  assign cif.relay_neg   = q.neg;
endmodule

// ---- core/tss_top.sv ----
/*
  trigger, self-test and wait sequencer with apb registers.
  assumes apb on clock_i; listener and level-busy pins asynchronous;
  presence, straps and questionable flags on clock_i.
*/
// Decided for this implementation: register access over APB and the address map.
// Overview of operation
// (RULE1) trigger makes an event only while armed
// (RULE2) event loads trigger levels, clears waiting flag
// (RULE3) continuous arming rearms and sets waiting flag
// (RULE4) trigger and group-execute need listener addressing
// (RULE5) init arms one trigger; redundant when continuous
// (RULE6) after a trigger others are ignored until rearmed
// (RULE7) relays: open, max pos, zero, swap, max neg, zero pos
// (RULE8) relayless modules get the same levels directly
// (RULE9) errors set questionable flags; pass only if zero
// (RULE10) test all connected modules; result zero or failures
// (RULE11) host reads failing status, then repeats the test
// (RULE12) wait stalls later accesses until outputs settle
// (RULE13) power loss clears levels and settings
// (RULE14) continuous arming follows setting; reset forces off
// (RULE15) becoming armed sets the waiting flag
module tss_top #(
  parameter int NMOD     = tss_pkg::NMOD,
  parameter int QW       = tss_pkg::QW,
  parameter int STEP_CYC = tss_pkg::STEP_CYC
) (
  // clock, reset, enable
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  // apb slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [tss_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [tss_pkg::DATA_W-1:0]  pwdata_i,
  output logic      [tss_pkg::DATA_W-1:0]  prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // interrupt
  output logic                             irq_o,
  // instrument bus and module side inputs
  input  wire logic                        listen_i,
  input  wire logic                        level_busy_i,
  input  wire logic [NMOD-1:0]             present_i,
  input  wire logic [NMOD-1:0]             has_relay_i,
  input  wire logic [NMOD*QW-1:0]          ques_i,
  // module drive outputs
  output logic      [tss_pkg::LVL_W-1:0]   volt_o,
  output logic      [tss_pkg::LVL_W-1:0]   curr_o,
  output logic                             wtg_o,
  output logic                             test_active_o,
  output tss_pkg::lvl_t                    test_level_o,
  output logic                             measure_o,
  output logic      [NMOD-1:0]             relay_close_o,
  output logic      [NMOD-1:0]             relay_neg_o
);
  import tss_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  // (RULE13) power-on clears everything
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else if (ce_i) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // sub-units
  // ----------------------------------------------------------------
  tss_ctl_if #(.NMOD(NMOD)) cif ();

  tss_trigger u_trig (
    .clock_i (clock_i),
    .rst_n_i (rst_s2_q),
    .ce_i    (ce_i),
    .cif     (cif)
  );

  tss_selftest #(
    .NMOD     (NMOD),
    .STEP_CYC (STEP_CYC)
  ) u_test (
    .clock_i (clock_i),
    .rst_n_i (rst_s2_q),
    .ce_i    (ce_i),
    .cif     (cif)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int QCW = $clog2(QUIET_CYC + 1);
  localparam logic [QCW-1:0] QUIET_END = QCW'(QUIET_CYC);

  typedef struct packed {
    logic              listen_s1;
    logic              listen_s2;
    logic              busy_s1;
    logic              busy_s2;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              irq;
    logic [IRQ_W-1:0]  istat;
    logic [IRQ_W-1:0]  imask;
    logic [LVL_W-1:0]  trig_volt;
    logic [LVL_W-1:0]  trig_curr;
    logic [LVL_W-1:0]  out_volt;
    logic [LVL_W-1:0]  out_curr;
    logic              out_chg;
    logic              wai_pend;
    logic [QCW-1:0]    quiet;
    logic              init;
    logic              trg;
    logic              get;
    logic              rst_cmd;
    logic              cont_wr;
    logic              cont_val;
    logic              test_start;
  } top_state_t;

  top_state_t        q;
  top_state_t        d;
  logic              acc;
  logic              wr;
  logic              hit;
  logic [DATA_W-1:0] rdata;
  logic [IRQ_W-1:0]  ev;
  logic [NMOD-1:0]   ques_nz;

  // questionable flags reduced per module
  always_comb begin
    ques_nz = '0;
    for (int i = 0; i < NMOD; i++) begin
      ques_nz[i] = |ques_i[i*QW +: QW];
    end
  end

  assign cif.init       = q.init;
  assign cif.trg        = q.trg;
  assign cif.get        = q.get;
  assign cif.listen     = q.listen_s2;
  assign cif.cont_wr    = q.cont_wr;
  assign cif.cont_val   = q.cont_val;
  assign cif.rst_cmd    = q.rst_cmd;
  assign cif.test_start = q.test_start;
  assign cif.present    = present_i;
  assign cif.has_relay  = has_relay_i;
  assign cif.ques_nz    = ques_nz;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d            = q;
    rdata        = '0;
    hit          = 1'b1;
    ev           = '0;
    // pin synchronisers
    d.listen_s1  = listen_i;
    d.listen_s2  = q.listen_s1;
    d.busy_s1    = level_busy_i;
    d.busy_s2    = q.busy_s1;
    // command strobes last one cycle
    d.init       = 1'b0;
    d.trg        = 1'b0;
    d.get        = 1'b0;
    d.rst_cmd    = 1'b0;
    d.cont_wr    = 1'b0;
    d.cont_val   = 1'b0;
    d.test_start = 1'b0;
    d.out_chg    = 1'b0;
    d.pready     = 1'b0;
    d.pslverr    = 1'b0;

    // read decode
    case (paddr_i)
      OFS_CTRL: begin
        rdata[CB_CONT] = cif.cont;
      end
      OFS_STATUS: begin
        rdata[SB_WTG]  = cif.wtg;
        rdata[SB_BUSY] = cif.test_busy;
        rdata[SB_WAI]  = q.wai_pend;
        rdata[SB_LSTN] = q.listen_s2;
      end
      OFS_TRIG_VOLT: rdata[LVL_W-1:0] = q.trig_volt;
      OFS_TRIG_CURR: rdata[LVL_W-1:0] = q.trig_curr;
      OFS_OUT_VOLT:  rdata[LVL_W-1:0] = q.out_volt;
      OFS_OUT_CURR:  rdata[LVL_W-1:0] = q.out_curr;
      // (RULE10) zero or failing addresses
      OFS_RESULT:    rdata[NMOD-1:0]  = cif.fail;
      OFS_IRQ_STAT:  rdata[IRQ_W-1:0] = q.istat;
      OFS_IRQ_MASK:  rdata[IRQ_W-1:0] = q.imask;
      default:       hit = 1'b0;
    endcase

    // apb answer, one wait state
    acc = psel_i & penable_i;
    // (RULE12) stall accesses while waiting
    if (acc & ~q.pready & ~q.wai_pend) begin
      d.pready  = 1'b1;
      d.pslverr = ~hit;
      d.prdata  = pwrite_i ? '0 : rdata;
    end
    wr = acc & q.pready & pwrite_i & hit;

    // writes land at the completing edge
    if (wr) begin
      case (paddr_i)
        OFS_CTRL: begin
          d.cont_wr    = 1'b1;
          d.cont_val   = pwdata_i[CB_CONT];
          d.init       = pwdata_i[CB_INIT];
          d.trg        = pwdata_i[CB_TRG];
          d.get        = pwdata_i[CB_GET];
          d.rst_cmd    = pwdata_i[CB_RST];
          d.test_start = pwdata_i[CB_TEST];
          d.wai_pend   = pwdata_i[CB_WAI];
          if (pwdata_i[CB_RST]) begin
            d.out_volt = LVL_RST;
            d.out_curr = LVL_RST;
            d.out_chg  = 1'b1;
          end
        end
        OFS_TRIG_VOLT: d.trig_volt = pwdata_i[LVL_W-1:0];
        OFS_TRIG_CURR: d.trig_curr = pwdata_i[LVL_W-1:0];
        OFS_OUT_VOLT: begin
          d.out_volt = pwdata_i[LVL_W-1:0];
          d.out_chg  = 1'b1;
        end
        OFS_OUT_CURR: begin
          d.out_curr = pwdata_i[LVL_W-1:0];
          d.out_chg  = 1'b1;
        end
        OFS_IRQ_MASK: d.imask = pwdata_i[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // (RULE2) trigger loads stored levels
    if (cif.fire) begin
      d.out_volt = q.trig_volt;
      d.out_curr = q.trig_curr;
      d.out_chg  = 1'b1;
    end

    // (RULE12) quiet count after last change
    if (q.busy_s2 | q.out_chg | cif.test_busy | q.init | q.trg | q.get | q.test_start) begin
      d.quiet = '0;
    end else if (q.quiet != QUIET_END) begin
      d.quiet = QCW'(q.quiet + 1'b1);
    end
    if (q.wai_pend & (q.quiet == QUIET_END) & ~wr) begin
      d.wai_pend = 1'b0;
      ev[IB_WAI] = 1'b1;
    end

    // sticky events, set wins over clear
    ev[IB_TRIG] = cif.fire;
    ev[IB_TEST] = cif.test_done;
    if (wr & (paddr_i == OFS_IRQ_STAT)) begin
      d.istat = q.istat & ~pwdata_i[IRQ_W-1:0];
    end
    d.istat = d.istat | ev;
    d.irq   = |(d.istat & d.imask);
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      // (RULE13) levels and settings lost
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o      = q.prdata;
  assign pready_o      = q.pready;
  assign pslverr_o     = q.pslverr;
  assign irq_o         = q.irq;
  assign volt_o        = q.out_volt;
  assign curr_o        = q.out_curr;
  assign wtg_o         = cif.wtg;
  assign test_active_o = cif.test_busy;
  assign test_level_o  = cif.test_level;
  assign measure_o     = cif.measure;
  assign relay_close_o = cif.relay_close;
  assign relay_neg_o   = cif.relay_neg;
endmodule

// ---- verif/tss_asserts.sv ----
/*
  port checks of the sequencer top.
  assumes a bind onto tss_top, one clock.
*/
module tss_asserts #(
  parameter int NMOD = 4
) (
  // clock and reset
  input wire logic                       clock_i,
  input wire logic                       resetn_i,
  // apb
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic                       pready_o,
  input wire logic                       pslverr_o,
  // module side
  input wire logic [NMOD-1:0]            has_relay_i,
  input wire logic [tss_pkg::LVL_W-1:0]  volt_o,
  input wire logic                       wtg_o,
  input wire logic                       test_active_o,
  input tss_pkg::lvl_t                   test_level_o,
  input wire logic [NMOD-1:0]            relay_close_o,
  input wire logic [NMOD-1:0]            relay_neg_o
);
  import tss_pkg::*;
  logic [3:0] wr_age_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // cycles since last apb write, saturating
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) wr_age_q <= 4'hf;
    else if (psel_i && penable_i && pready_o && pwrite_i) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("stray pslverr");
  a_arm_needs_cmd: assert property ($rose(wtg_o) |-> wr_age_q <= 4'h4)
    else $error("armed unasked");
  a_level_needs_cmd: assert property ($changed(volt_o) |-> wr_age_q <= 4'h5)
    else $error("level moved unasked");
  a_open_at_start: assert property ($rose(test_active_o) |->
    relay_close_o == '0 && test_level_o == LVL_ZERO) else $error("relays not open");
  a_relay_pos_max: assert property (test_level_o == LVL_POS |->
    relay_close_o == has_relay_i && relay_neg_o == '0) else $error("bad relays at pos");
  a_relay_neg_max: assert property (test_level_o == LVL_NEG |->
    relay_neg_o == has_relay_i) else $error("relays not swapped");
  a_end_zero_pos: assert property ($fell(test_active_o) |->
    test_level_o == LVL_ZERO && relay_neg_o == '0) else $error("test end not zero");
  c_fire: cover property ($fell(wtg_o));
  c_test: cover property ($rose(test_active_o));
  c_slverr: cover property (pslverr_o);
endmodule

bind tss_top tss_asserts #(.NMOD(NMOD)) u_asserts (
  .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .has_relay_i(has_relay_i), .volt_o(volt_o), .wtg_o(wtg_o),
  .test_active_o(test_active_o), .test_level_o(test_level_o),
  .relay_close_o(relay_close_o), .relay_neg_o(relay_neg_o)
);

// ---- verif/tss_field.sv ----
/*
  behavioural power modules: settling and questionable flags.
  assumes drive on clock_i; the bench injects faults.
*/
module tss_field (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // sequencer drive
  input  wire logic [15:0]  volt_i,
  input  wire logic         measure_i,
  // bench control
  input  wire logic [3:0]   inject_i,
  input  wire logic         clear_i,
  // module status
  output logic              level_busy_o,
  output logic [63:0]       ques_o,
  output logic [7:0]        meas_cnt_o
);
  logic [15:0] volt_q;
  logic [4:0]  settle_q;
  logic [3:0]  err_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      volt_q <= 16'h0000;
      settle_q <= 5'h00;
      err_q <= 4'h0;
      meas_cnt_o <= 8'h00;
    end else begin
      volt_q <= volt_i;
      if (volt_i != volt_q) settle_q <= 5'h14;
      else if (settle_q != 5'h00) settle_q <= settle_q - 5'h01;
      err_q <= clear_i ? 4'h0 : err_q | (measure_i ? inject_i : 4'h0);
      meas_cnt_o <= meas_cnt_o + {7'h00, measure_i};
    end
  end
  // one flag in bit 0 of each module word
  always_comb begin
    ques_o = '0;
    for (int i = 0; i < 4; i++) ques_o[i*16] = err_q[i];
  end
  assign level_busy_o = settle_q != 5'h00;
endmodule

// ---- verif/trigger_selftest_sequencer_test.sv ----
/*
  apb bench of the sequencer.
  assumes tss_top with 4-cycle steps and tss_field.
*/
module trigger_selftest_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tss_pkg::*;
  logic        clock_i = 1'h0;
  logic        resetn_i = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, listen = 1'h0, clear = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  inject = 4'ha, rc, rn;
  logic [63:0] ques;
  logic [15:0] volt, curr;
  logic [7:0]  mc, mc0;
  logic        pready, pslverr, perr, irq, busy, wtg, tact, meas;
  lvl_t        lvl;
  int          n_errors = 0, checks = 0, cyc;
  // free-running clock
  always #2 clock_i = ~clock_i;
  tss_top #(.STEP_CYC(4)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'h1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .listen_i(listen), .level_busy_i(busy), .present_i(4'h7), .has_relay_i(4'h3),
    .ques_i(ques), .volt_o(volt), .curr_o(curr), .wtg_o(wtg), .test_active_o(tact),
    .test_level_o(lvl), .measure_o(meas), .relay_close_o(rc), .relay_neg_o(rn)
  );
  tss_field model (
    .clock_i(clock_i), .resetn_i(resetn_i), .volt_i(volt), .measure_i(meas),
    .inject_i(inject), .clear_i(clear), .level_busy_o(busy), .ques_o(ques), .meas_cnt_o(mc)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    n_errors++;
    $display("wrong value at %0t: no answer", $time);
    end_sim;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task idle(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  // one apb transfer
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'h1 && k < 400);
    if (k >= 400) hang;
    rdv = prdata;
    perr = pslverr;
    cyc = k;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0);
  endtask
  // self-test, poll till idle
  task tst_run;
    int k;
    mc0 = mc;
    wr(OFS_CTRL, 32'h20);
    rd(OFS_STATUS);
    chk(rdv[1], 1'h1, "busy");
    k = 0;
    while (rdv[1] !== 1'h0 && k < 50) begin
      rd(OFS_STATUS);
      k++;
    end
    if (k >= 50) hang;
    chk(mc - mc0, 8'h03, "measures");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(3);
    resetn_i <= 1'h1;
    idle(3);
    rd(OFS_STATUS);
    chk(rdv, 32'h0, "status");
    rd(8'h40);
    chk({rdv, perr}, 33'h1, "unmapped");
    $display("test reset done");
    listen <= 1'h1;
    wr(OFS_TRIG_VOLT, 32'h1234);
    wr(OFS_TRIG_CURR, 32'h0056);
    wr(OFS_CTRL, 32'h4);
    idle(8);
    chk(volt, 16'h0, "unarmed");
    wr(OFS_CTRL, 32'h2);
    idle(8);
    chk(wtg, 1'h1, "init");
    wr(OFS_CTRL, 32'h8);
    idle(8);
    chk({wtg, volt, curr}, {1'h0, 16'h1234, 16'h0056}, "fire");
    wr(OFS_TRIG_VOLT, 32'h0777);
    wr(OFS_CTRL, 32'h4);
    idle(8);
    chk(volt, 16'h1234, "one shot");
    listen <= 1'h0;
    wr(OFS_CTRL, 32'h2);
    wr(OFS_CTRL, 32'h4);
    idle(8);
    chk({wtg, volt}, {1'h1, 16'h1234}, "not listener");
    listen <= 1'h1;
    wr(OFS_CTRL, 32'h4);
    idle(8);
    chk(volt, 16'h0777, "listener");
    wr(OFS_CTRL, 32'h1);
    idle(8);
    chk(wtg, 1'h1, "cont on");
    wr(OFS_TRIG_VOLT, 32'h0aaa);
    wr(OFS_CTRL, 32'h5);
    idle(8);
    chk({wtg, volt}, {1'h1, 16'h0aaa}, "rearm");
    wr(OFS_TRIG_VOLT, 32'h0bbb);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h9);
    idle(8);
    chk({wtg, volt}, {1'h1, 16'h0bbb}, "init redundant");
    wr(OFS_CTRL, 32'h10);
    idle(8);
    rd(OFS_CTRL);
    chk({rdv[0], wtg, volt}, 18'h0, "reset cmd");
    rd(OFS_IRQ_STAT);
    chk(rdv[0], 1'h1, "fired flag");
    wr(OFS_IRQ_MASK, 32'h1);
    idle(3);
    chk(irq, 1'h1, "irq on");
    wr(OFS_IRQ_STAT, 32'h7);
    idle(3);
    chk(irq, 1'h0, "irq clear");
    $display("test trigger done");
    tst_run;
    rd(OFS_RESULT);
    chk(rdv, 32'h2, "failing");
    inject <= 4'h0;
    clear <= 1'h1;
    idle(1);
    clear <= 1'h0;
    tst_run;
    rd(OFS_RESULT);
    chk(rdv, 32'h0, "retest");
    $display("test selftest done");
    wr(OFS_OUT_VOLT, 32'h0321);
    wr(OFS_CTRL, 32'h40);
    rd(OFS_OUT_VOLT);
    chk({cyc >= 10, rdv}, {1'h1, 32'h0321}, "wait stall");
    $display("test wait done");
    wr(OFS_TRIG_VOLT, 32'h0055);
    wr(OFS_IRQ_MASK, 32'h7);
    resetn_i <= 1'h0;
    idle(3);
    resetn_i <= 1'h1;
    idle(3);
    rd(OFS_TRIG_VOLT);
    chk(rdv, 32'h0, "lost level");
    rd(OFS_IRQ_MASK);
    chk(rdv, 32'h0, "lost mask");
    $display("test power loss done");
    end_sim;
  end
endmodule
